// file: logic/cir_pkg.sv
//****************************************************************
// Overview of operation
//****************************************************************
`default_nettype none
package cir_pkg;
    // Register addresses
    localparam logic [7:0] CIR_ADDR_OUT_CFG = 8'h10;
    localparam logic [7:0] CIR_ADDR_CLK_SEL = 8'h11;
    localparam logic [7:0] CIR_ADDR_DATA_SEL = 8'h12;
    localparam logic [7:0] CIR_ADDR_MIC = 8'h13;
    localparam logic [7:0] CIR_ADDR_PWR = 8'h14;
    localparam logic [7:0] CIR_ADDR_BIAS = 8'h15;
    localparam logic [7:0] CIR_ADDR_ASI0 = 8'h18;
    // Reset values
    localparam logic [7:0] CIR_RST_OUT_CFG = 8'h52;
    localparam logic [7:0] CIR_RST_CLK_SEL = 8'h80;
    localparam logic [7:0] CIR_RST_DATA_SEL = 8'h00;
    localparam logic [7:0] CIR_RST_MIC = 8'h00;
    localparam logic [7:0] CIR_RST_PWR = 8'h00;
    localparam logic [7:0] CIR_RST_BIAS = 8'h00;
    localparam logic [7:0] CIR_RST_ASI0 = 8'h40;
    // Writable bits; reserved bits hold zero
    localparam logic [7:0] CIR_WMASK_CLK_SEL = 8'hfe;
    localparam logic [7:0] CIR_WMASK_DATA_SEL = 8'hfc;
    localparam logic [7:0] CIR_WMASK_BIAS = 8'hf0;
    // Field positions
    localparam int CIR_B_PRIM_EN = 7;
    localparam int CIR_L_FRAME = 4;
    localparam int CIR_L_CLOCK = 1;
    localparam int CIR_L_DIN = 5;
    localparam int CIR_L_DIN2 = 2;
    localparam int CIR_B_TYPE1 = 7;
    localparam int CIR_B_TYPE2 = 6;
    localparam int CIR_B_EDGE_A = 5;
    localparam int CIR_B_EDGE_B = 4;
    localparam int CIR_L_MIC_A = 2;
    localparam int CIR_L_MIC_B = 0;
    localparam int CIR_B_OVRD = 7;
    localparam int CIR_B_SHARED = 6;
    localparam int CIR_L_ADC_PD = 4;
    localparam int CIR_L_DAC_PD = 2;
    localparam int CIR_B_POWER_LIMITER = 1;
    localparam int CIR_B_AUX_AMP = 0;
    localparam int CIR_L_BIAS = 6;
    localparam int CIR_L_CONV = 4;
    localparam int CIR_L_OUT_FUNC = 4;
    localparam int CIR_B_SEC_DIS = 6;
    // Source codes
    localparam logic [2:0] CIR_SRC_OFF = 3'h0;
    localparam logic [2:0] CIR_SRC_PIN_A = 3'h1;
    localparam logic [2:0] CIR_SRC_PIN_B = 3'h2;
    localparam logic [2:0] CIR_SRC_GPI = 3'h3;
    localparam logic [2:0] CIR_SRC_DOUT = 3'h4;
    localparam logic [2:0] CIR_SRC_PRIM = 3'h5;
    // Output pin function codes
    localparam logic [3:0] CIR_OUT_OFF = 4'h0;
    localparam logic [3:0] CIR_OUT_INPUT = 4'h1;
    localparam logic [3:0] CIR_OUT_PRIM_DATA = 4'h5;
    localparam logic [3:0] CIR_OUT_RSVD = 4'hf;
    localparam int CIR_SYNC_STAGES = 2;

    typedef struct packed {
        logic pin_a;
        logic pin_b;
        logic gpi;
        logic din;
        logic dout_in;
        logic prim_frame;
        logic prim_clock;
        logic mic_clk;
    } cir_pins_t;

    typedef struct packed {
        logic enable;
        logic frame;
        logic clock;
        logic din;
        logic din2;
    } cir_sec_port_t;

    typedef struct packed {
        logic adc_pd;
        logic dac_pd;
        logic power_limit;
        logic aux_amp;
        logic mic_bias;
        logic conv_start;
    } cir_ctrl_t;
endpackage
`default_nettype wire

// file: logic/cir_sync.sv
`default_nettype none
module cir_sync
    import cir_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule
`default_nettype wire

// file: logic/cir_pin_routing.sv
`default_nettype none
module cir_pin_routing
    import cir_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire cir_pins_t pins_i,
    input wire logic prim_dout_i,
    input wire logic dout_other_i,
    input wire logic adc_power_bit_i,
    input wire logic dac_power_bit_i,
    output logic primary_din_o,
    output cir_sec_port_t sec_port_o,
    output logic [1:0] record_type_o,
    output logic [3:0] pdm_data_o,
    output logic [3:0] pdm_strobe_o,
    output cir_ctrl_t ctrl_o,
    output logic dout_pin_o,
    output logic dout_pin_oe_o
);
    //****************************************************************
    // Reset release
    //****************************************************************
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    //****************************************************************
    // Pin synchronisers
    //****************************************************************
    cir_pins_t pins_s;

    cir_sync #(
        .WIDTH($bits(cir_pins_t))
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_ff),
        .async_i(pins_i),
        .sync_o(pins_s)
    );

    //****************************************************************
    // Configuration registers
    //****************************************************************
    logic [7:0] out_cfg_ff, clk_sel_ff, data_sel_ff, mic_ff, pwr_ff, bias_ff, asi0_ff, rdata_ff;
    logic [7:0] nxt_out_cfg, nxt_clk_sel, nxt_data_sel, nxt_mic, nxt_pwr, nxt_bias, nxt_asi0, nxt_rdata;

    always_comb begin
        nxt_out_cfg = out_cfg_ff;
        nxt_clk_sel = clk_sel_ff;
        nxt_data_sel = data_sel_ff;
        nxt_mic = mic_ff;
        nxt_pwr = pwr_ff;
        nxt_bias = bias_ff;
        nxt_asi0 = asi0_ff;
        if (reg_wr_i) begin
            case (reg_addr_i)
                CIR_ADDR_OUT_CFG: nxt_out_cfg = reg_wdata_i;
                CIR_ADDR_CLK_SEL: nxt_clk_sel = reg_wdata_i & CIR_WMASK_CLK_SEL;
                CIR_ADDR_DATA_SEL: nxt_data_sel = reg_wdata_i & CIR_WMASK_DATA_SEL;
                CIR_ADDR_MIC: nxt_mic = reg_wdata_i;
                CIR_ADDR_PWR: nxt_pwr = reg_wdata_i;
                CIR_ADDR_BIAS: nxt_bias = reg_wdata_i & CIR_WMASK_BIAS;
                CIR_ADDR_ASI0: nxt_asi0 = reg_wdata_i;
                default: nxt_out_cfg = out_cfg_ff;
            endcase
        end
        case (reg_addr_i)
            CIR_ADDR_OUT_CFG: nxt_rdata = out_cfg_ff;
            CIR_ADDR_CLK_SEL: nxt_rdata = clk_sel_ff;
            CIR_ADDR_DATA_SEL: nxt_rdata = data_sel_ff;
            CIR_ADDR_MIC: nxt_rdata = mic_ff;
            CIR_ADDR_PWR: nxt_rdata = pwr_ff;
            CIR_ADDR_BIAS: nxt_rdata = bias_ff;
            CIR_ADDR_ASI0: nxt_rdata = asi0_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            out_cfg_ff <= CIR_RST_OUT_CFG;
            clk_sel_ff <= CIR_RST_CLK_SEL;
            data_sel_ff <= CIR_RST_DATA_SEL;
            mic_ff <= CIR_RST_MIC;
            pwr_ff <= CIR_RST_PWR;
            bias_ff <= CIR_RST_BIAS;
            asi0_ff <= CIR_RST_ASI0;
            rdata_ff <= 8'h00;
        end else begin
            out_cfg_ff <= nxt_out_cfg;
            clk_sel_ff <= nxt_clk_sel;
            data_sel_ff <= nxt_data_sel;
            mic_ff <= nxt_mic;
            pwr_ff <= nxt_pwr;
            bias_ff <= nxt_bias;
            asi0_ff <= nxt_asi0;
            rdata_ff <= nxt_rdata;
        end
    end

    //****************************************************************
    // Source selection
    //****************************************************************
    // Six-way selector; reserved codes yield a quiet zero
    function automatic logic pick3(input logic [2:0] code, input cir_pins_t p, input logic dout_ok,
                                   input logic prim);
        case (code)
            CIR_SRC_PIN_A: pick3 = p.pin_a;
            CIR_SRC_PIN_B: pick3 = p.pin_b;
            CIR_SRC_GPI: pick3 = p.gpi;
            CIR_SRC_DOUT: pick3 = dout_ok & p.dout_in;
            CIR_SRC_PRIM: pick3 = prim;
            default: pick3 = 1'b0;
        endcase
    endfunction

    // Four-way pin selector; override swaps input-only pin for serial input
    function automatic logic pick2(input logic [1:0] code, input cir_pins_t p, input logic ovrd);
        case (code)
            2'h1: pick2 = p.pin_a;
            2'h2: pick2 = p.pin_b;
            2'h3: pick2 = ovrd ? p.din : p.gpi;
            default: pick2 = 1'b0;
        endcase
    endfunction

    logic [2:0] frame_code, clock_code, din_code, din2_code;
    logic [1:0] mic_a_code, mic_b_code;
    logic [3:0] out_func;
    logic shared, ovrd, dout_in_ok, mic_a_dat, mic_b_dat;

    assign frame_code = clk_sel_ff[CIR_L_FRAME +: 3];
    assign clock_code = clk_sel_ff[CIR_L_CLOCK +: 3];
    assign din_code = data_sel_ff[CIR_L_DIN +: 3];
    assign din2_code = data_sel_ff[CIR_L_DIN2 +: 3];
    assign mic_a_code = mic_ff[CIR_L_MIC_A +: 2];
    assign mic_b_code = mic_ff[CIR_L_MIC_B +: 2];
    assign out_func = out_cfg_ff[CIR_L_OUT_FUNC +: 4];
    assign shared = pwr_ff[CIR_B_SHARED];
    assign ovrd = pwr_ff[CIR_B_OVRD];
    assign dout_in_ok = shared | (out_func == CIR_OUT_INPUT);
    assign mic_a_dat = pick2(mic_a_code, pins_s, ovrd);
    assign mic_b_dat = pick2(mic_b_code, pins_s, ovrd);

    //****************************************************************
    // Routed outputs
    //****************************************************************
    logic primary_din_ff, nxt_primary_din;
    cir_sec_port_t sec_ff, nxt_sec;
    cir_ctrl_t ctrl_ff, nxt_ctrl;
    logic dout_ff, nxt_dout, dout_oe_ff, nxt_dout_oe;
    logic [1:0] type_ff, nxt_type;

    always_comb begin
        nxt_primary_din = clk_sel_ff[CIR_B_PRIM_EN] & pins_s.din;
        nxt_sec.enable = (frame_code != CIR_SRC_OFF) & ~asi0_ff[CIR_B_SEC_DIS];
        nxt_sec.frame = pick3(frame_code, pins_s, 1'b0, pins_s.prim_frame);
        nxt_sec.clock = pick3(clock_code, pins_s, 1'b0, pins_s.prim_clock);
        nxt_sec.din = pick3(din_code, pins_s, dout_in_ok, pins_s.din);
        nxt_sec.din2 = pick3(din2_code, pins_s, dout_in_ok, pins_s.din);
        nxt_ctrl.adc_pd = ~adc_power_bit_i | pick2(pwr_ff[CIR_L_ADC_PD +: 2], pins_s, 1'b0);
        nxt_ctrl.dac_pd = ~dac_power_bit_i | pick2(pwr_ff[CIR_L_DAC_PD +: 2], pins_s, 1'b0);
        nxt_ctrl.power_limit = pwr_ff[CIR_B_POWER_LIMITER] & pins_s.pin_a;
        nxt_ctrl.aux_amp = pwr_ff[CIR_B_AUX_AMP] & pins_s.pin_a;
        nxt_ctrl.mic_bias = pick2(bias_ff[CIR_L_BIAS +: 2], pins_s, 1'b0);
        nxt_ctrl.conv_start = pick2(bias_ff[CIR_L_CONV +: 2], pins_s, 1'b0);
        nxt_type = {mic_ff[CIR_B_TYPE2], mic_ff[CIR_B_TYPE1]};
        // Output pin: shared mode drives primary data and listens too
        if (shared) begin
            nxt_dout = prim_dout_i;
            nxt_dout_oe = 1'b1;
        end else begin
            case (out_func)
                CIR_OUT_OFF, CIR_OUT_INPUT, CIR_OUT_RSVD: begin
                    nxt_dout = 1'b0;
                    nxt_dout_oe = 1'b0;
                end
                CIR_OUT_PRIM_DATA: begin
                    nxt_dout = prim_dout_i;
                    nxt_dout_oe = 1'b1;
                end
                default: begin
                    nxt_dout = dout_other_i;
                    nxt_dout_oe = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            primary_din_ff <= 1'b0;
            sec_ff <= '0;
            ctrl_ff <= '0;
            dout_ff <= 1'b0;
            dout_oe_ff <= 1'b0;
            type_ff <= 2'h0;
        end else begin
            primary_din_ff <= nxt_primary_din;
            sec_ff <= nxt_sec;
            ctrl_ff <= nxt_ctrl;
            dout_ff <= nxt_dout;
            dout_oe_ff <= nxt_dout_oe;
            type_ff <= nxt_type;
        end
    end

    //****************************************************************
    // Microphone capture
    //****************************************************************
    logic mic_clk_d_ff, nxt_mic_clk_d;
    logic [3:0] pdm_ff, nxt_pdm, strobe_ff, nxt_strobe;
    logic rise, fall;
    logic [3:0] take;

    assign rise = pins_s.mic_clk & ~mic_clk_d_ff;
    assign fall = ~pins_s.mic_clk & mic_clk_d_ff;

    always_comb begin
        nxt_mic_clk_d = pins_s.mic_clk;
        take[0] = (mic_a_code != 2'h0) & (mic_ff[CIR_B_EDGE_A] ? rise : fall);
        take[1] = (mic_a_code != 2'h0) & (mic_ff[CIR_B_EDGE_A] ? fall : rise);
        take[2] = (mic_b_code != 2'h0) & (mic_ff[CIR_B_EDGE_B] ? rise : fall);
        take[3] = (mic_b_code != 2'h0) & (mic_ff[CIR_B_EDGE_B] ? fall : rise);
        nxt_strobe = take;
        nxt_pdm = pdm_ff;
        if (take[0]) begin
            nxt_pdm[0] = mic_a_dat;
        end
        if (take[1]) begin
            nxt_pdm[1] = mic_a_dat;
        end
        if (take[2]) begin
            nxt_pdm[2] = mic_b_dat;
        end
        if (take[3]) begin
            nxt_pdm[3] = mic_b_dat;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            mic_clk_d_ff <= 1'b0;
            pdm_ff <= 4'h0;
            strobe_ff <= 4'h0;
        end else begin
            mic_clk_d_ff <= nxt_mic_clk_d;
            pdm_ff <= nxt_pdm;
            strobe_ff <= nxt_strobe;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign primary_din_o = primary_din_ff;
    assign sec_port_o = sec_ff;
    assign ctrl_o = ctrl_ff;
    assign record_type_o = type_ff;
    assign pdm_data_o = pdm_ff;
    assign pdm_strobe_o = strobe_ff;
    assign dout_pin_o = dout_ff;
    assign dout_pin_oe_o = dout_oe_ff;

    //****************************************************************
    // Assertions
    //****************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_ff);

    prim_din_gate_a: assert property ($past(clk_sel_ff[CIR_B_PRIM_EN]) == 1'b0 |-> !primary_din_o)
        else $error("primary input passed while disabled");
    frame_prim_a: assert property (frame_code == CIR_SRC_PRIM ##1 frame_code == CIR_SRC_PRIM
        |-> sec_port_o.frame == $past(pins_s.prim_frame))
        else $error("frame source not primary frame");
    clock_pin_b_a: assert property (clock_code == CIR_SRC_PIN_B |=> sec_port_o.clock == $past(pins_s.pin_b))
        else $error("clock source not pin B");
    din_dout_a: assert property (din_code == CIR_SRC_DOUT && !dout_in_ok |=> !sec_port_o.din)
        else $error("output pin read while not an input");
    pin_latency_a: assert property (pwr_ff[CIR_B_POWER_LIMITER] [*4] ##0 $rose(pins_i.pin_a)
        |-> ##3 ctrl_o.power_limit)
        else $error("power limit not following pin A in three cycles");
    mic_ovrd_a: assert property (mic_a_code == 2'h3 && ovrd && take[0] |=> pdm_data_o[0] == $past(pins_s.din))
        else $error("override did not route serial input");
    edge_sel_a: assert property (mic_a_code != 2'h0 && !mic_ff[CIR_B_EDGE_A] && fall |=> pdm_strobe_o[0])
        else $error("channel 1 not taken on falling edge");
    adc_pd_a: assert property (!adc_power_bit_i |=> ctrl_o.adc_pd)
        else $error("converter not powered down by register");
    shared_oe_a: assert property (shared |=> dout_pin_oe_o && dout_pin_o == $past(prim_dout_i))
        else $error("shared pin not driving primary data");
    out_func_a: assert property (!shared && out_func == CIR_OUT_INPUT |=> !dout_pin_oe_o)
        else $error("output pin driven while input");
    bias_pin_a: assert property (bias_ff[CIR_L_BIAS +: 2] == 2'h0 |=> !ctrl_o.mic_bias)
        else $error("bias enabled with no source");
    sec_enable_a: assert property (frame_code == CIR_SRC_OFF |=> !sec_port_o.enable)
        else $error("secondary port enabled with no frame source");
    din2_pin_a: assert property (din2_code == CIR_SRC_PIN_A
        |=> sec_port_o.din2 == $past(pins_s.pin_a))
        else $error("second input not pin A");
    rec_type_a: assert property (record_type_o[0] == $past(mic_ff[CIR_B_TYPE1]))
        else $error("channel 1 type wrong");
    edge_b_a: assert property (mic_b_code != 2'h0 && mic_ff[CIR_B_EDGE_B] && rise |=> pdm_strobe_o[2])
        else $error("channel 3 not taken on rising edge");
    mic_b_pin_a: assert property (mic_b_code == 2'h2 && take[3]
        |=> pdm_data_o[3] == $past(pins_s.pin_b))
        else $error("channel 4 not from pin B");
    mic_a_off_a: assert property (mic_a_code == 2'h0 |=> pdm_strobe_o[1:0] == 2'h0)
        else $error("pair A captured while off");
    dac_off_a: assert property (dac_power_bit_i && pwr_ff[CIR_L_DAC_PD +: 2] == 2'h0 |=> !ctrl_o.dac_pd)
        else $error("playback converter down with no request");
    power_limiter_off_a: assert property (!pwr_ff[CIR_B_POWER_LIMITER] |=> !ctrl_o.power_limit)
        else $error("power limit active while pin control off");
    aux_amp_a: assert property (pwr_ff[CIR_B_AUX_AMP]
        |=> ctrl_o.aux_amp == $past(pins_s.pin_a))
        else $error("aux amplifier not following pin A");
    conv_off_a: assert property (bias_ff[CIR_L_CONV +: 2] == 2'h0 |=> !ctrl_o.conv_start)
        else $error("conversion start with no source");
    ovrd_off_a: assert property (mic_a_code == 2'h3 && !ovrd && take[0]
        |=> pdm_data_o[0] == $past(pins_s.gpi))
        else $error("input-only pin not used without override");
    out_prim_a: assert property (!shared && out_func == CIR_OUT_PRIM_DATA
        |=> dout_pin_oe_o && dout_pin_o == $past(prim_dout_i))
        else $error("output pin not driving primary data");
    adc_pin_a: assert property (adc_power_bit_i && pwr_ff[CIR_L_ADC_PD +: 2] == 2'h1
        |=> ctrl_o.adc_pd == $past(pins_s.pin_a))
        else $error("converter power-down not following pin A");
    bias_pin_b_a: assert property (bias_ff[CIR_L_BIAS +: 2] == 2'h2
        |=> ctrl_o.mic_bias == $past(pins_s.pin_b))
        else $error("bias enable not following pin B");

    shared_cov_c: cover property (shared ##1 sec_port_o.din);
    pdm_cov_c: cover property (pdm_strobe_o[0] ##[1:20] pdm_strobe_o[1]);
    sec_cov_c: cover property (sec_port_o.enable && sec_port_o.clock);
    ovrd_cov_c: cover property (ovrd && pdm_strobe_o[0]);
    power_limiter_cov_c: cover property (ctrl_o.power_limit);
endmodule
`default_nettype wire

// file: testbench/cir_pin_model.sv
`default_nettype none
module cir_pin_model
    import cir_pkg::*;
(
    input wire logic clk_sys_i,
    input wire cir_pins_t level_i,
    input wire logic mic_run_i,
    input wire logic [2:0] mic_pin_i,
    input wire logic fall_val_i,
    input wire logic rise_val_i,
    output cir_pins_t pins_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic mic_clk = 1'b0;
    logic mic_dat = 1'b0;
    int phase = 0;
    //****************************************************************
    // Microphone clock and data
    //****************************************************************
    // Clock runs at one sixteenth of the system clock and stands low between bursts
    always @(posedge clk_sys_i) begin
        #1;
        if (mic_run_i) begin
            phase = (phase + 1) % 16;
            mic_clk = (phase >= 8);
            // Data moves mid-phase so each edge sees a settled bit
            if (phase == 4) begin
                mic_dat = rise_val_i;
            end else if (phase == 12) begin
                mic_dat = fall_val_i;
            end
        end else begin
            phase = 0;
            mic_clk = 1'b0;
            mic_dat = ~mic_dat;
        end
    end
    always_comb begin
        pins_o = level_i;
        pins_o.mic_clk = mic_clk;
        case (mic_pin_i)
            3'h1: pins_o.pin_a = mic_dat;
            3'h2: pins_o.pin_b = mic_dat;
            3'h3: pins_o.gpi = mic_dat;
            3'h4: pins_o.din = mic_dat;
            default: ;
        endcase
    end
endmodule
`default_nettype wire

// file: testbench/cir_pin_routing_tb.sv
`default_nettype none
module cir_pin_routing_tb
    import cir_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic arst_n, wr, prim_dout, dout_other, adc_bit, dac_bit, mic_run, fall_val, rise_val, primary_din;
    logic dout_pin, dout_oe;
    logic [7:0] addr, wdata, rdata;
    logic [2:0] mic_pin;
    logic [1:0] rec_type;
    logic [3:0] pdm_data, pdm_strobe;
    cir_pins_t lvl, pins;
    cir_sec_port_t sec;
    cir_ctrl_t ctrl, exp_ctrl;
    int fail_count = 0;
    int checks = 0;
    int strobe_cnt[4];
    logic [7:0] map_addr[8] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h18, 8'h16};
    logic [7:0] map_rst[8] = '{CIR_RST_OUT_CFG, CIR_RST_CLK_SEL, CIR_RST_DATA_SEL, CIR_RST_MIC,
                               CIR_RST_PWR, CIR_RST_BIAS, CIR_RST_ASI0, 8'h00};
    always #50 clk = ~clk;
    cir_pin_model model_u (.clk_sys_i(clk), .level_i(lvl), .mic_run_i(mic_run), .mic_pin_i(mic_pin),
        .fall_val_i(fall_val), .rise_val_i(rise_val), .pins_o(pins));
    cir_pin_routing dut_u (.clk_sys_i(clk), .arst_n_i(arst_n), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .pins_i(pins), .prim_dout_i(prim_dout),
        .dout_other_i(dout_other), .adc_power_bit_i(adc_bit), .dac_power_bit_i(dac_bit),
        .primary_din_o(primary_din), .sec_port_o(sec), .record_type_o(rec_type), .pdm_data_o(pdm_data),
        .pdm_strobe_o(pdm_strobe), .ctrl_o(ctrl), .dout_pin_o(dout_pin), .dout_pin_oe_o(dout_oe));
    always @(negedge clk) begin
        for (int j = 0; j < 4; j++) begin
            if (pdm_strobe[j] === 1'b1) strobe_cnt[j]++;
        end
    end
    //****************************************************************
    // Access and compare tasks
    //****************************************************************
    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk);
        #1 wr = 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        @(posedge clk);
        #1 chk8("register read", exp, rdata);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic src_bit(input logic [2:0] code, input cir_pins_t p, input logic dout_ok,
                                     input logic prim);
        case (code)
            3'h1: return p.pin_a;
            3'h2: return p.pin_b;
            3'h3: return p.gpi;
            3'h4: return dout_ok & p.dout_in;
            3'h5: return prim;
            default: return 1'b0;
        endcase
    endfunction
    task automatic report_and_stop;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    //****************************************************************
    // Tests
    //****************************************************************
    initial begin
        arst_n = 1'b0; wr = 1'b0; addr = 8'h00; wdata = 8'h00; lvl = '0; prim_dout = 1'b0;
        dout_other = 1'b0; adc_bit = 1'b1; dac_bit = 1'b1; mic_run = 1'b0; mic_pin = 3'h0;
        fall_val = 1'b1; rise_val = 1'b0;
        repeat (20) @(posedge clk);
        #1 arst_n = 1'b1;
        settle(3);
        for (int i = 0; i < 8; i++) rd_reg(map_addr[i], map_rst[i]);
        wr_reg(8'h11, 8'hff);
        rd_reg(8'h11, 8'hfe);
        wr_reg(8'h12, 8'hff);
        rd_reg(8'h12, 8'hfc);
        wr_reg(8'h15, 8'hff);
        rd_reg(8'h15, 8'hf0);
        wr_reg(8'h16, 8'hff);
        rd_reg(8'h16, 8'h00);
        lvl = cir_pins_t'(8'hb5);
        wr_reg(8'h11, 8'h80);
        settle(5);
        chk8("primary din on", 8'h01, {7'h0, primary_din});
        wr_reg(8'h11, 8'h00);
        settle(5);
        chk8("primary din off", 8'h00, {7'h0, primary_din});
        wr_reg(8'h18, 8'h00);
        for (int c = 0; c < 8; c++) begin
            for (int k = 0; k < 4; k++) begin
                lvl = cir_pins_t'(k[0] ? 8'hb5 : 8'h4a);
                wr_reg(8'h11, {1'b1, c[2:0], c[2:0], 1'b0});
                wr_reg(8'h12, {c[2:0], c[2:0], 2'b00});
                wr_reg(8'h14, {1'b0, k[1], 6'h00});
                settle(5);
                chk8("frame", {7'h0, src_bit(c[2:0], lvl, 1'b0, lvl.prim_frame)}, {7'h0, sec.frame});
                chk8("clock", {7'h0, src_bit(c[2:0], lvl, 1'b0, lvl.prim_clock)}, {7'h0, sec.clock});
                chk8("sec enable", {7'h0, c != 0}, {7'h0, sec.enable});
                chk8("din", {7'h0, src_bit(c[2:0], lvl, k[1], lvl.din)}, {7'h0, sec.din});
                chk8("din2", {7'h0, src_bit(c[2:0], lvl, k[1], lvl.din)}, {7'h0, sec.din2});
            end
        end
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 2; k++) begin
                lvl = cir_pins_t'(k[0] ? 8'hb5 : 8'h4a);
                adc_bit = k[0];
                dac_bit = ~k[0];
                wr_reg(8'h14, {2'b00, c[1:0], c[1:0], c[0], c[1]});
                wr_reg(8'h15, {c[1:0], c[1:0], 4'h0});
                settle(5);
                exp_ctrl.adc_pd = src_bit({1'b0, c[1:0]}, lvl, 1'b0, 1'b0) | ~adc_bit;
                exp_ctrl.dac_pd = src_bit({1'b0, c[1:0]}, lvl, 1'b0, 1'b0) | ~dac_bit;
                exp_ctrl.power_limit = c[0] & lvl.pin_a;
                exp_ctrl.aux_amp = c[1] & lvl.pin_a;
                exp_ctrl.mic_bias = src_bit({1'b0, c[1:0]}, lvl, 1'b0, 1'b0);
                exp_ctrl.conv_start = src_bit({1'b0, c[1:0]}, lvl, 1'b0, 1'b0);
                chk8("ctrl", {2'b00, exp_ctrl}, {2'b00, ctrl});
            end
        end
        for (int k = 0; k < 10; k++) begin
            prim_dout = k[0];
            dout_other = ~k[0];
            wr_reg(8'h14, k / 2 == 4 ? 8'h40 : 8'h00);
            wr_reg(8'h10, {(k / 2 == 4) ? 4'h0 : (k / 2 == 3) ? 4'h2 : (k / 2 == 2) ? 4'h1 :
                           (k / 2 == 1) ? 4'h0 : 4'h5, 4'h2});
            settle(5);
            chk8("dout oe", {7'h0, k / 2 != 1 && k / 2 != 2}, {7'h0, dout_oe});
            if (k / 2 != 1 && k / 2 != 2) chk8("dout", {7'h0, k / 2 == 3 ? ~k[0] : k[0]}, {7'h0, dout_pin});
        end
        for (int i = 0; i < 9; i++) begin
            fall_val = i[0];
            rise_val = ~i[0];
            wr_reg(8'h14, i == 8 ? 8'h80 : 8'h00);
            wr_reg(8'h13, {i[0], i[1], i[2], ~i[2], (i == 8) ? 2'h3 : i[1:0], (i == 8) ? 2'h3 : i[1:0]});
            mic_pin = (i == 8) ? 3'h4 : {1'b0, i[1:0]};
            for (int j = 0; j < 4; j++) strobe_cnt[j] = 0;
            mic_run = 1'b1;
            settle(72);
            chk8("record type", {6'h0, i[1], i[0]}, {6'h0, rec_type});
            chk8("strobes", {4'h0, {4{i[1:0] != 2'h0 || i == 8}}},
                 {4'h0, strobe_cnt[3] > 0, strobe_cnt[2] > 0, strobe_cnt[1] > 0, strobe_cnt[0] > 0});
            if (i[1:0] != 2'h0 || i == 8) begin
                chk8("mic data", {4'h0, i[2] ? {rise_val, fall_val, fall_val, rise_val}
                                            : {fall_val, rise_val, rise_val, fall_val}},
                     {4'h0, pdm_data});
            end
            mic_run = 1'b0;
            settle(8);
        end
        report_and_stop();
    end
    initial begin
        repeat (30000) @(posedge clk);
        fail_count++;
        $display("CHECK FAILED watchdog expected done seen running");
        report_and_stop();
    end
endmodule
`default_nettype wire
